// file: design/fdr_cfg.svh
// timing counts, field positions and register map of the fault diagnostic reporter
`ifndef FDR_CFG_SVH
`define FDR_CFG_SVH
`define FDR_CLK_HZ 100000000
`define FDR_CYC_PER_MS (`FDR_CLK_HZ / 1000)
`define FDR_LOW_UV_MS 2500
`define FDR_LOW_OT_MS 2000
`define FDR_LOW_ML_MS 1500
`define FDR_LOW_SD_MS 1000
`define FDR_HIGH_MS 1000
`define FDR_ADDR_STATUS 4'h0
`define FDR_ADDR_FAULT_INDICATOR_PIN 4'h1
`define FDR_ADDR_MASK 4'h2
`define FDR_ADDR_CONFIG 4'h3
`define FDR_ADDR_IRQ_STAT 4'h4
`define FDR_ADDR_IRQ_CLR 4'h5
`define FDR_ADDR_IRQ_EN 4'h6
`define FDR_ADDR_SPEED_MAX 4'h7
`define FDR_FF_BIT 15
`define FDR_MASK_RST 16'h0000
`define FDR_CFG_RST 16'h0000
`define FDR_SPEED_MAX_RST 16'hffff
`endif

// file: design/fdr_pkg.sv
// types of the fault diagnostic reporter
package fdr_pkg;
   typedef enum logic [1:0] {
      FDR_DGS_LEVEL,
      FDR_DGS_TACH,
      FDR_DGS_PULSE,
      FDR_DGS_PULSE_TACH
   } fdr_dgs_e;
   typedef enum logic [2:0] {
      FDR_GRP_NONE,
      FDR_GRP_MOTOR_LOCK,
      FDR_GRP_SHORT,
      FDR_GRP_TEMP,
      FDR_GRP_UNDERV,
      FDR_GRP_SYSTEM
   } fdr_grp_e;
   typedef enum logic [1:0] {
      FDR_PS_IDLE,
      FDR_PS_LOW,
      FDR_PS_HIGH
   } fdr_ps_e;
   // raw fault conditions, high while detected
   typedef struct packed {
      logic system_err;
      logic serial_err;
      logic main_por;
      logic main_uv;
      logic logic_uv;
      logic gate_uv;
      logic boot_uv;
      logic temp_warn;
      logic over_temp;
      logic loss_sync;
      logic [5:0] vds_ov;
      logic [5:0] boot_uv_ph;
   } fdr_fault_s;
   // register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [15:0] wdata;
   } fdr_bus_s;
endpackage

// file: design/fdr_fault_fault_indicator_pin_reporter.sv
// diagnostic latches, serial fault flag, and open-drain indicator pin
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "fdr_cfg.svh"

module fdr_fault_fault_indicator_pin_reporter
   import fdr_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // fault sources and speed
   input wire fdr_fault_s fault_in,
   input wire logic speed_tach_signal,
   input wire logic [15:0] motor_speed,
   // serial strobe from host pin
   input wire logic serial_strobe_n,
   // register port
   input wire fdr_bus_s bus,
   output logic [15:0] rdata,
   // serial output, indicator pin, demand hold and interrupt
   output logic sdo_data,
   output logic fault_indicator_pin_o,
   output logic fault_indicator_pin_oe_n,
   output logic demand_hold,
   output logic irq
);
   localparam int unsigned LOW_UV = `FDR_LOW_UV_MS * `FDR_CYC_PER_MS;
   localparam int unsigned LOW_OT = `FDR_LOW_OT_MS * `FDR_CYC_PER_MS;
   localparam int unsigned LOW_ML = `FDR_LOW_ML_MS * `FDR_CYC_PER_MS;
   localparam int unsigned LOW_SD = `FDR_LOW_SD_MS * `FDR_CYC_PER_MS;
   localparam int unsigned HIGH_T = `FDR_HIGH_MS * `FDR_CYC_PER_MS;

   // status layout: [15] any, [9] system, [8] serial, [7] por, [6] main uv,
   // [5] logic uv, [4] gate uv, [3] boot uv, [2] temp warn, [1] over temp, [0] loss sync
   function automatic logic [15:0] status_of(input fdr_fault_s f);
      status_of = {6'h00, f.system_err, f.serial_err, f.main_por, f.main_uv,
                   f.logic_uv, f.gate_uv, f.boot_uv, f.temp_warn, f.over_temp,
                   f.loss_sync};
   endfunction

   function automatic fdr_grp_e group_of(input logic [15:0] st, input logic [15:0] dg);
      if (st[9])
         group_of = FDR_GRP_SYSTEM;
      else if (|st[6:3])
         group_of = FDR_GRP_UNDERV;
      else if (st[1])
         group_of = FDR_GRP_TEMP;
      else if (|dg[11:6])
         group_of = FDR_GRP_SHORT;
      else if (st[0])
         group_of = FDR_GRP_MOTOR_LOCK;
      else
         group_of = FDR_GRP_NONE;
   endfunction

   function automatic logic [31:0] low_time(input fdr_grp_e g);
      case (g)
         FDR_GRP_UNDERV: low_time = LOW_UV;
         FDR_GRP_TEMP: low_time = LOW_OT;
         FDR_GRP_SHORT: low_time = LOW_SD;
         default: low_time = LOW_ML;
      endcase
   endfunction

   // strobe synchroniser, first stage read only by second
   logic strb_s1_ff, strb_s2_ff;
   always_ff @(posedge clk) begin
      strb_s1_ff <= sys_rst ? 1'b1 : serial_strobe_n;
      strb_s2_ff <= sys_rst ? 1'b1 : strb_s1_ff;
   end

   // registers
   logic [15:0] status_ff, nxt_status;
   logic [15:0] fault_indicator_pin_ff, nxt_fault_indicator_pin;
   logic [15:0] mask_ff, nxt_mask;
   logic [15:0] cfg_ff, nxt_cfg;
   logic [15:0] spmax_ff, nxt_spmax;
   logic [2:0] ie_ff, nxt_ie;
   logic [2:0] is_ff, nxt_is;
   logic [15:0] rdata_ff, nxt_rdata;
   logic any_fault_flag;
   logic grp_chg;
   logic [15:0] st_raw, dg_raw;
   logic read_clear_inhibit;
   fdr_dgs_e indicator_select;
   logic [7:0] clkdiv_sel;
   logic clkout_en;

   // config: [1:0] indicator select, [2] read-clear inhibit, [3] clock out, [15:8] divider
   assign indicator_select = fdr_dgs_e'(cfg_ff[1:0]);
   assign read_clear_inhibit = cfg_ff[2];
   assign clkout_en = cfg_ff[3];
   assign clkdiv_sel = cfg_ff[15:8];

   // raw events after masking; system, por, gate uv are critical, never masked
   always_comb begin
      st_raw = status_of(fault_in) & ~(mask_ff & 16'h016f);
      dg_raw = {3'h0, motor_speed > spmax_ff, fault_in.vds_ov, fault_in.boot_uv_ph}
               & ~{3'h0, mask_ff[15], 12'h000};
   end

   assign any_fault_flag = |status_ff[9:0] | |fault_indicator_pin_ff[12:0];

   // register file and latches
   always_comb begin
      nxt_mask = mask_ff;
      nxt_cfg = cfg_ff;
      nxt_spmax = spmax_ff;
      nxt_ie = ie_ff;
      nxt_is = is_ff;
      nxt_status = status_ff;
      nxt_fault_indicator_pin = fault_indicator_pin_ff;
      nxt_rdata = 16'h0000;
      if (bus.wr) begin
         if (bus.addr == `FDR_ADDR_MASK)
            nxt_mask = bus.wdata;
         else if (bus.addr == `FDR_ADDR_CONFIG)
            nxt_cfg = bus.wdata;
         else if (bus.addr == `FDR_ADDR_IRQ_CLR)
            nxt_is = is_ff & ~bus.wdata[2:0];
         else if (bus.addr == `FDR_ADDR_IRQ_EN)
            nxt_ie = bus.wdata[2:0];
         else if (bus.addr == `FDR_ADDR_SPEED_MAX)
            nxt_spmax = bus.wdata;
      end
      if (bus.rd) begin
         if (bus.addr == `FDR_ADDR_STATUS) begin
            nxt_rdata = {any_fault_flag, status_ff[14:0]};
            if (!read_clear_inhibit)
               nxt_status = 16'h0000;
         end else if (bus.addr == `FDR_ADDR_FAULT_INDICATOR_PIN) begin
            nxt_rdata = {any_fault_flag, fault_indicator_pin_ff[14:0]};
            if (!read_clear_inhibit)
               nxt_fault_indicator_pin = 16'h0000;
         end else if (bus.addr == `FDR_ADDR_MASK)
            nxt_rdata = mask_ff;
         else if (bus.addr == `FDR_ADDR_CONFIG)
            nxt_rdata = cfg_ff;
         else if (bus.addr == `FDR_ADDR_IRQ_STAT)
            nxt_rdata = {13'h0000, is_ff};
         else if (bus.addr == `FDR_ADDR_IRQ_EN)
            nxt_rdata = {13'h0000, ie_ff};
         else if (bus.addr == `FDR_ADDR_SPEED_MAX)
            nxt_rdata = spmax_ff;
      end
      nxt_status = nxt_status | st_raw;
      nxt_fault_indicator_pin = nxt_fault_indicator_pin | dg_raw;
      // events: new status fault, new fault_indicator_pin fault, indicator group change
      nxt_is = nxt_is | {grp_chg, |(dg_raw & ~fault_indicator_pin_ff), |(st_raw & ~status_ff)};
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         status_ff <= 16'h0000;
         fault_indicator_pin_ff <= 16'h0000;
         mask_ff <= `FDR_MASK_RST;
         cfg_ff <= `FDR_CFG_RST;
         spmax_ff <= `FDR_SPEED_MAX_RST;
         ie_ff <= 3'h0;
         is_ff <= 3'h0;
         rdata_ff <= 16'h0000;
      end else begin
         status_ff <= nxt_status;
         fault_indicator_pin_ff <= nxt_fault_indicator_pin;
         mask_ff <= nxt_mask;
         cfg_ff <= nxt_cfg;
         spmax_ff <= nxt_spmax;
         ie_ff <= nxt_ie;
         is_ff <= nxt_is;
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata = rdata_ff;
   assign irq = |(is_ff & ie_ff);

   // clock divider for calibration output, toggles every divider+1 cycles
   logic [7:0] div_cnt_ff, nxt_div_cnt;
   logic div_clk_ff, nxt_div_clk;
   always_comb begin
      nxt_div_cnt = div_cnt_ff + 8'h01;
      nxt_div_clk = div_clk_ff;
      if (div_cnt_ff >= clkdiv_sel) begin
         nxt_div_cnt = 8'h00;
         nxt_div_clk = ~div_clk_ff;
      end
   end

   // serial output
   logic sdo_ff, nxt_sdo;
   always_comb begin
      nxt_sdo = 1'b0;
      if (clkout_en)
         nxt_sdo = nxt_div_clk;
      else if (!strb_s2_ff)
         nxt_sdo = any_fault_flag;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         div_cnt_ff <= 8'h00;
         div_clk_ff <= 1'b0;
         sdo_ff <= 1'b0;
      end else begin
         div_cnt_ff <= nxt_div_cnt;
         div_clk_ff <= nxt_div_clk;
         sdo_ff <= nxt_sdo;
      end
   end
   assign sdo_data = sdo_ff;

   // pulse pattern generator; long counts mean the group is sampled once per cycle
   fdr_ps_e ps_ff, nxt_ps;
   fdr_grp_e grp_ff, nxt_grp;
   logic [31:0] pcnt_ff, nxt_pcnt;
   fdr_grp_e cur_grp;
   logic tach_s1_ff, tach_s2_ff;

   always_ff @(posedge clk) begin
      tach_s1_ff <= sys_rst ? 1'b1 : speed_tach_signal;
      tach_s2_ff <= sys_rst ? 1'b1 : tach_s1_ff;
   end

   assign cur_grp = group_of(status_ff, fault_indicator_pin_ff);
   assign grp_chg = (cur_grp != grp_ff) && (ps_ff == FDR_PS_IDLE || cur_grp == FDR_GRP_NONE);

   always_comb begin
      nxt_ps = ps_ff;
      nxt_grp = grp_ff;
      nxt_pcnt = pcnt_ff;
      case (ps_ff)
         FDR_PS_IDLE: begin
            nxt_grp = cur_grp;
            if (cur_grp != FDR_GRP_NONE && cur_grp != FDR_GRP_SYSTEM) begin
               nxt_ps = FDR_PS_LOW;
               nxt_pcnt = low_time(cur_grp) - 32'd1;
            end
         end
         FDR_PS_LOW: begin
            if (cur_grp == FDR_GRP_SYSTEM || cur_grp == FDR_GRP_NONE) begin
               nxt_ps = FDR_PS_IDLE;
            end else if (pcnt_ff == 32'd0) begin
               nxt_ps = FDR_PS_HIGH;
               nxt_pcnt = HIGH_T - 32'd1;
            end else
               nxt_pcnt = pcnt_ff - 32'd1;
         end
         default: begin
            if (cur_grp == FDR_GRP_SYSTEM || cur_grp == FDR_GRP_NONE)
               nxt_ps = FDR_PS_IDLE;
            else if (pcnt_ff == 32'd0) begin
               nxt_ps = FDR_PS_LOW;
               nxt_grp = cur_grp;
               nxt_pcnt = low_time(cur_grp) - 32'd1;
            end else
               nxt_pcnt = pcnt_ff - 32'd1;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ps_ff <= FDR_PS_IDLE;
         grp_ff <= FDR_GRP_NONE;
         pcnt_ff <= 32'd0;
      end else begin
         ps_ff <= nxt_ps;
         grp_ff <= nxt_grp;
         pcnt_ff <= nxt_pcnt;
      end
   end

   // indicator pin level: 1 released, 0 pulled low
   logic pin_ff, nxt_pin;
   logic pulse_lvl;
   always_comb begin
      pulse_lvl = !(cur_grp == FDR_GRP_SYSTEM || ps_ff == FDR_PS_LOW);
      case (indicator_select)
         FDR_DGS_LEVEL: nxt_pin = (cur_grp == FDR_GRP_NONE);
         FDR_DGS_TACH: nxt_pin = tach_s2_ff;
         FDR_DGS_PULSE: nxt_pin = (cur_grp == FDR_GRP_NONE) ? 1'b1 : pulse_lvl;
         default: nxt_pin = (cur_grp == FDR_GRP_NONE) ? tach_s2_ff : pulse_lvl;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst)
         pin_ff <= 1'b1;
      else
         pin_ff <= nxt_pin;
   end

   // open drain: output always low, enable low while pulling
   assign fault_indicator_pin_o = 1'b0;
   assign fault_indicator_pin_oe_n = pin_ff;
   assign demand_hold = (indicator_select == FDR_DGS_PULSE) && !pin_ff;

endmodule // fdr_fault_fault_indicator_pin_reporter

// file: testbench/fdr_checker.sv
// port checker of the fault reporter
`timescale 1ns/1ps
module fdr_checker
   import fdr_pkg::*;
(
   // clock, reset, inputs
   input wire logic clk,
   input wire logic sys_rst,
   input wire fdr_fault_s fault_in,
   input wire logic speed_tach_signal,
   input wire logic serial_strobe_n,
   input wire fdr_bus_s bus,
   // outputs
   input wire logic [15:0] rdata,
   input wire logic sdo_data,
   input wire logic fault_indicator_pin_o,
   input wire logic fault_indicator_pin_oe_n,
   input wire logic demand_hold
);
   logic [15:0] cfg_ff, nxt_cfg;
   logic [7:0] age_ff, nxt_age;
   logic [8:0] run_ff, nxt_run, div_len;
   logic [1:0] seen_ff, nxt_seen;
   logic sdo_ff, chg;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // config shadow; loads on the same edge as the real register
   assign chg = sdo_data != sdo_ff;
   assign div_len = {1'b0, cfg_ff[15:8]} + 9'h001;
   always_comb begin
      nxt_cfg = cfg_ff;
      nxt_age = age_ff + {7'h00, age_ff != 8'hff};
      nxt_run = chg ? 9'h001 : run_ff + 9'h001;
      nxt_seen = seen_ff + {1'b0, chg && seen_ff != 2'h3};
      if (bus.wr && bus.addr == 4'h3) begin
         nxt_cfg = bus.wdata;
         nxt_age = 8'h00;
         nxt_seen = 2'h0;
      end
   end
   // first divider run may be partial, so only runs after two edges count
   always_ff @(posedge clk) begin
      sdo_ff <= sdo_data;
      run_ff <= sys_rst ? 9'h000 : nxt_run;
      cfg_ff <= sys_rst ? 16'h0000 : nxt_cfg;
      age_ff <= sys_rst ? 8'h00 : nxt_age;
      seen_ff <= sys_rst ? 2'h0 : nxt_seen;
   end
   property p_rd_idle;
      !$past(bus.rd) |-> rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
   property p_ff;
      $past(bus.rd) && $past(bus.addr) == 4'h0 && rdata[9:0] != 10'h000 |-> rdata[15];
   endproperty
   a_ff: assert property (p_ff) else $error("flag low with status bits");
   property p_od;
      fault_indicator_pin_o == 1'b0;
   endproperty
   a_od: assert property (p_od) else $error("pin driven high");
   property p_level;
      fault_in.gate_uv[*5] ##0 (cfg_ff[1:0] == 2'h0 && age_ff > 8'h03)
         |-> !fault_indicator_pin_oe_n;
   endproperty
   a_level: assert property (p_level) else $error("level pin released");
   property p_tach;
      $stable(speed_tach_signal)[*4] ##0 (cfg_ff[1:0] == 2'h1 && age_ff > 8'h08)
         |-> fault_indicator_pin_oe_n == speed_tach_signal;
   endproperty
   a_tach: assert property (p_tach) else $error("pin not tach");
   property p_demand;
      demand_hold |-> cfg_ff[1:0] == 2'h2 && !fault_indicator_pin_oe_n;
   endproperty
   a_demand: assert property (p_demand) else $error("hold outside low");
   property p_sys;
      fault_in.system_err[*5] ##0 (cfg_ff[1] && age_ff > 8'h08) |-> !fault_indicator_pin_oe_n;
   endproperty
   a_sys: assert property (p_sys) else $error("system error not low");
   property p_sdo_idle;
      serial_strobe_n[*4] ##0 (!cfg_ff[3] && age_ff > 8'h04) |-> !sdo_data;
   endproperty
   a_sdo_idle: assert property (p_sdo_idle) else $error("sdo without strobe");
   property p_div;
      cfg_ff[3] && seen_ff >= 2'h2 |-> (chg ? run_ff == div_len : run_ff < div_len);
   endproperty
   a_div: assert property (p_div) else $error("divider period wrong");
   c_flag: cover property ($past(bus.rd) && rdata[15]);
   c_hold: cover property (demand_hold);
   c_div: cover property (cfg_ff[3] && seen_ff == 2'h3);
endmodule // fdr_checker

bind fdr_fault_fault_indicator_pin_reporter fdr_checker u_fdr_checker (
   .clk(clk), .sys_rst(sys_rst), .fault_in(fault_in), .speed_tach_signal(speed_tach_signal),
   .serial_strobe_n(serial_strobe_n), .bus(bus), .rdata(rdata), .sdo_data(sdo_data),
   .fault_indicator_pin_o(fault_indicator_pin_o), .demand_hold(demand_hold),
   .fault_indicator_pin_oe_n(fault_indicator_pin_oe_n)
);

// file: testbench/fdr_host_model.sv
// host side of the serial pin: strobe and flag sample
`timescale 1ns/1ps
module fdr_host_model (
   // clock, request, data
   input wire logic clk,
   input wire logic req,
   input wire logic sdo_data,
   // strobe and sampled flag
   output logic serial_strobe_n = 1'b1,
   output logic flag_seen = 1'b0
);
   always_ff @(posedge clk) begin
      serial_strobe_n <= !req;
      flag_seen <= !serial_strobe_n & sdo_data;
   end
endmodule // fdr_host_model

// file: testbench/tb.sv
// self-checking bench of the fault reporter
`timescale 1ns/1ps
module tb;
   import fdr_pkg::*;
   localparam logic [21:0] OT = 22'h002000, TW = 22'h004000, GUV = 22'h010000;
   localparam logic [21:0] SYS = 22'h200000;
   logic clk = 1'b0, sys_rst = 1'b1, tach = 1'b1, req = 1'b0, rd_pend = 1'b0, s;
   logic serial_strobe_n, flag_seen, sdo_data, pin_o, oe_n, demand_hold, irq;
   logic [15:0] motor_speed = 16'h0000, rdata;
   logic [11:0] ph;
   fdr_fault_s fault_in = '0;
   fdr_bus_s bus = '0;
   logic [15:0] exp_q[$];
   int failures = 0, n_compared = 0, seed = 5567, i, n;
   always #5 clk = ~clk;
   fdr_fault_fault_indicator_pin_reporter u_fdr_fault_fault_indicator_pin_reporter (.clk(clk), .sys_rst(sys_rst),
      .fault_in(fault_in), .speed_tach_signal(tach), .motor_speed(motor_speed),
      .serial_strobe_n(serial_strobe_n), .bus(bus), .rdata(rdata), .sdo_data(sdo_data),
      .fault_indicator_pin_o(pin_o), .fault_indicator_pin_oe_n(oe_n),
      .demand_hold(demand_hold), .irq(irq));
   fdr_host_model u_fdr_host_model (.clk(clk), .req(req), .sdo_data(sdo_data),
      .serial_strobe_n(serial_strobe_n), .flag_seen(flag_seen));
   task automatic conclude;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // bounded wait; running out ends the run
   task automatic waitfor(ref logic sig, input logic e);
      for (int k = 0; k < 30 && sig !== e; k++) @(posedge clk);
      cmp({15'h0, sig}, {15'h0, e});
      if (sig !== e) conclude();
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      exp_q.push_back(e);
      @(posedge clk);
      bus.rd <= 1'b0;
   endtask
   task automatic pulse(input logic [21:0] f);
      @(posedge clk);
      fault_in <= f;
      repeat (6) @(posedge clk);
      fault_in <= '0;
      repeat (6) @(posedge clk);
   endtask
   // read data stand only in the cycle after the strobe
   always @(posedge clk) rd_pend <= bus.rd;
   always @(negedge clk) begin
      if (rd_pend) cmp(rdata, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);
   end
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      rd(4'h7, 16'hffff);
      rd(4'h2, 16'h0000);
      wr(4'h9, 16'hffff);
      rd(4'h9, 16'h0000);
      // interrupt masked, enabled, cleared
      pulse(TW);
      waitfor(irq, 1'b0);
      wr(4'h6, 16'h0001);
      waitfor(irq, 1'b1);
      rd(4'h4, 16'h0001);
      wr(4'h5, 16'h0001);
      waitfor(irq, 1'b0);
      waitfor(oe_n, 1'b1);
      rd(4'h0, 16'h8004);
      rd(4'h0, 16'h0000);
      // inhibit keeps bits across a read
      wr(4'h3, 16'h0004);
      pulse(OT);
      waitfor(oe_n, 1'b0);
      rd(4'h0, 16'h8002);
      rd(4'h0, 16'h8002);
      wr(4'h3, 16'h0000);
      rd(4'h0, 16'h8002);
      rd(4'h0, 16'h0000);
      waitfor(oe_n, 1'b1);
      wr(4'h2, 16'h03ff);
      pulse(OT | GUV);
      rd(4'h0, 16'h8010);
      wr(4'h2, 16'h0000);
      // random phase detail and overspeed
      ph = 12'($random(seed));
      wr(4'h7, 16'h8000);
      motor_speed <= 16'h8001 | 16'($random(seed));
      pulse({10'h000, ph});
      motor_speed <= 16'h0000;
      rd(4'h0, 16'h8000);
      rd(4'h1, {4'h9, ph});
      rd(4'h1, 16'h0000);
      // status, fault_indicator_pin and group events all pending, then cleared
      rd(4'h4, 16'h0007);
      wr(4'h5, 16'h0007);
      rd(4'h4, 16'h0000);
      wr(4'h3, 16'h0001);
      fault_in <= OT;
      for (i = 0; i < 4; i++) begin
         tach <= ~tach;
         repeat (10) @(posedge clk);
         cmp({15'h0, oe_n}, {15'h0, tach});
      end
      wr(4'h3, 16'h0003);
      waitfor(oe_n, 1'b0);
      fault_in <= '0;
      rd(4'h0, 16'h8002);
      waitfor(oe_n, 1'b1);
      tach <= 1'b0;
      waitfor(oe_n, 1'b0);
      wr(4'h3, 16'h0002);
      waitfor(oe_n, 1'b1);
      pulse(OT);
      waitfor(demand_hold, 1'b1);
      repeat (1000) @(posedge clk);
      cmp({15'h0, oe_n}, 16'h0000);
      fault_in <= SYS;
      repeat (8) @(posedge clk);
      fault_in <= '0;
      rd(4'h0, 16'h8202);
      waitfor(oe_n, 1'b1);
      wr(4'h3, 16'h0000);
      pulse(OT);
      req <= 1'b1;
      waitfor(flag_seen, 1'b1);
      req <= 1'b0;
      rd(4'h0, 16'h8002);
      req <= 1'b1;
      repeat (6) @(posedge clk);
      cmp({15'h0, flag_seen}, 16'h0000);
      req <= 1'b0;
      wr(4'h3, 16'h0308);
      repeat (20) @(posedge clk);
      n = 0;
      for (i = 0; i < 40; i++) begin
         s = sdo_data;
         @(posedge clk);
         n += int'(sdo_data !== s);
      end
      cmp(16'(n), 16'h000a);
      conclude();
   end
endmodule // tb
